// file: pkg/reset_init_pkg.sv
package reset_init_pkg;

    localparam int NREG  = 37;
    localparam int IDX_W = 6;

    // Slots of registers that the logic handles by name
    localparam int IDX_CORE_IRQ    = 0;
    localparam int IDX_REQ_FLAGS   = 1;
    localparam int IDX_SER_CTRL    = 2;
    localparam int IDX_ADC_HIGH    = 5;
    localparam int IDX_OPTION      = 7;
    localparam int IDX_DIR_A       = 8;
    localparam int IDX_DIR_B       = 9;
    localparam int IDX_PERIPH_EN   = 13;
    localparam int IDX_PWR_STAT    = 15;
    localparam int IDX_OSC_CTRL    = 16;
    localparam int IDX_T2_PERIOD   = 19;
    localparam int IDX_SLAVE_ADDR  = 20;
    localparam int IDX_ADDR_MASK   = 21;
    localparam int IDX_ADC_LOW     = 32;

    localparam logic [8:0] ALIAS_OPTION_ADDR = 9'h181;
    localparam logic [8:0] ALIAS_DIR_B_ADDR  = 9'h186;

    // Field positions
    localparam int GLOBAL_EN_BIT  = 7;
    localparam int PWR_BOR_BIT    = 0;
    localparam int PWR_POR_BIT    = 1;
    localparam int PWR_SBOR_BIT   = 4;
    localparam int OSC_STAT_LSB   = 1;
    localparam int OSC_STAT_MSB   = 3;

    localparam logic [3:0]  MASK_MODE     = 4'h9;
    localparam logic [12:0] IRQ_VECTOR    = 13'h0004;

    // Printed offsets, one per slot
    localparam logic [0:NREG-1][8:0] REG_ADDR = '{
        9'h00b, 9'h00c, 9'h014, 9'h01c, 9'h01d, 9'h01e, 9'h01f, 9'h081,
        9'h085, 9'h086, 9'h087, 9'h088, 9'h089, 9'h08c, 9'h08d, 9'h08e,
        9'h08f, 9'h090, 9'h091, 9'h092, 9'h093, 9'h093, 9'h094, 9'h095,
        9'h096, 9'h097, 9'h098, 9'h099, 9'h09a, 9'h09b, 9'h09c, 9'h09d,
        9'h09e, 9'h09f, 9'h105, 9'h107, 9'h108};

    // Power-on image; unknown contents start at zero
    localparam logic [0:NREG-1][7:0] POR_VAL = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h00, 8'h00, 8'h10,
        8'h60, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff,
        8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
        8'h00, 8'h00, 8'h08, 8'h00, 8'h00};

    // Implemented bits
    localparam logic [0:NREG-1][7:0] IMPL_MASK = '{
        8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hdf, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h33,
        8'h7f, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hf7, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f,
        8'hff, 8'hb0, 8'h1f, 8'hfb, 8'hfb};

    // Bits that software may write
    localparam logic [0:NREG-1][7:0] WR_MASK = '{
        8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h00, 8'hdf, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h33,
        8'h71, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hf7, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f,
        8'h00, 8'hb0, 8'h1f, 8'hfb, 8'hfb};

    // Bits kept across master-clear, watchdog and brown-out resets
    localparam logic [0:NREG-1][7:0] KEEP_WARM = '{
        8'h01, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h13,
        8'h00, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'hff, 8'h00, 8'h00, 8'h00, 8'h00};

    localparam logic [7:0] WAKE_RELOAD = 8'hff;

endpackage : reset_init_pkg

// file: rtl/level_sync.sv
`timescale 1ns/1ns
module level_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_t;

    sync_t s_q;
    sync_t s_d;

    // The first stage feeds only the second; metastability settles there
    always_comb begin
        s_d.stage1 = d;
        s_d.stage2 = s_q.stage1;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= {RESET_VAL, RESET_VAL};
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.stage2;

endmodule : level_sync

// file: rtl/reset_init_register_bank.sv
// Operation
// R1 - Unimplemented bits always read as zero, and unknown power-on contents may start at any value.
// R2 - A supply drop deep enough for power-on reset applies the power-on image, never the brown-out one.
// R3 - An interrupt that wakes the core from sleep leaves its flag set in the interrupt control or request register.
// R4 - A wake-up by interrupt with global enable set loads the program counter with vector 0004h.
// R5 - Brown-out reset clears bit 0 of the power status register and every other reset leaves it alone.
// R6 - Address 93h reaches the slave address register, and the address mask only while serial mode is 1001.
// R7 - Every reset clears the global interrupt enable bit.
// R8 - Warm resets reload power-on defaults except power and oscillator status, and sleep wake-up keeps contents; the code reloads period and mask on wake,
// and on warm resets also keeps 1Ch, 90h, the ADC results at 1Eh and 9Eh, and bit 0 of 0Bh.
`timescale 1ns/1ns
module reset_init_register_bank (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        master_clear_reset_pin_n,
    input  wire logic        brownout_detect,
    input  wire logic        watchdog_timer_timeout,
    input  wire logic        sleep_enter,
    input  wire logic [2:0]  core_irq_flag_set,
    input  wire logic [7:0]  periph_irq_flag_set,
    input  wire logic [2:0]  osc_status,
    input  wire logic        adc_result_valid,
    input  wire logic [15:0] adc_result,
    input  wire logic [8:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [7:0]  rdata_q,
    output logic             sleeping_q,
    output logic             wake_q,
    output logic             pc_vector_load_q,
    output logic      [12:0] pc_vector_addr_q,
    output logic             global_interrupt_enable_q,
    output logic      [3:0]  sync_serial_mode_select_q
);

    localparam int N = reset_init_pkg::NREG;

    typedef enum logic {PWR_RUN, PWR_SLEEP} power_t;

    typedef struct packed {
        logic                 hit;
        logic [reset_init_pkg::IDX_W-1:0] idx;
    } sel_t;

    typedef struct packed {
        logic [0:N-1][7:0] regs;
        power_t            pwr;
        logic [7:0]        rdata;
        logic              wake;
        logic              vec_load;
        logic [12:0]       vec_addr;
    } state_t;

    localparam state_t ST_POR = '{
        regs:     reset_init_pkg::POR_VAL,
        pwr:      PWR_RUN,
        rdata:    8'h00,
        wake:     1'b0,
        vec_load: 1'b0,
        vec_addr: 13'h0000
    };

    state_t      s_q;
    state_t      s_d;
    logic [1:0]  pins_sync;
    logic        master_clear_active;
    logic        bor_active;
    logic        warm_reset;
    logic        irq_wake;
    sel_t        sel;

    level_sync #(
        .WIDTH     (2),
        .RESET_VAL (2'b01)
    ) u_pin_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       ({brownout_detect, master_clear_reset_pin_n}),
        .q       (pins_sync)
    );

    assign master_clear_active = ~pins_sync[0];
    assign bor_active  = pins_sync[1];

    // Address decode; 93h is steered by the serial mode field
    function automatic sel_t find_reg(input logic [8:0] a, input logic [3:0] mode);
        sel_t       s;
        logic [8:0] f;
        s = '0;
        f = a;
        if (a == reset_init_pkg::ALIAS_OPTION_ADDR || a == reset_init_pkg::ALIAS_DIR_B_ADDR) begin
            f = {1'b0, a[7:0]};
        end
        for (int i = 0; i < N; i++) begin
            if (reset_init_pkg::REG_ADDR[i] == f &&
                !(i == reset_init_pkg::IDX_SLAVE_ADDR && mode == reset_init_pkg::MASK_MODE) &&
                !(i == reset_init_pkg::IDX_ADDR_MASK && mode != reset_init_pkg::MASK_MODE)) begin // R6
                s.hit = 1'b1;
                s.idx = i[reset_init_pkg::IDX_W-1:0];
            end
        end
        return s;
    endfunction : find_reg

    always_comb begin
        s_d          = s_q;
        s_d.wake     = 1'b0;
        s_d.vec_load = 1'b0;
        s_d.rdata    = 8'h00;
        sel          = find_reg(addr, s_q.regs[reset_init_pkg::IDX_SER_CTRL][3:0]);
        irq_wake     = |(core_irq_flag_set & s_q.regs[reset_init_pkg::IDX_CORE_IRQ][5:3]) |
                       |(periph_irq_flag_set & s_q.regs[reset_init_pkg::IDX_PERIPH_EN]);
        warm_reset   = master_clear_active | bor_active | (watchdog_timer_timeout & (s_q.pwr == PWR_RUN));

        // Read path; oscillator status bits come live from the clock unit
        if (rd_en && sel.hit) begin
            s_d.rdata = s_q.regs[sel.idx] & reset_init_pkg::IMPL_MASK[sel.idx]; // R1
            if (sel.idx == reset_init_pkg::IDX_W'(reset_init_pkg::IDX_OSC_CTRL)) begin
                s_d.rdata[reset_init_pkg::OSC_STAT_MSB:reset_init_pkg::OSC_STAT_LSB] = osc_status;
            end
        end

        // Write path; unimplemented and read-only bits never store
        if (wr_en && sel.hit) begin
            s_d.regs[sel.idx] = (s_q.regs[sel.idx] & ~reset_init_pkg::WR_MASK[sel.idx]) |
                                (wdata & reset_init_pkg::WR_MASK[sel.idx]); // R1
        end

        if (adc_result_valid) begin
            s_d.regs[reset_init_pkg::IDX_ADC_HIGH] = adc_result[15:8];
            s_d.regs[reset_init_pkg::IDX_ADC_LOW]  = adc_result[7:0];
        end

        // Flags are set after the write so a same-cycle clear cannot lose an event
        s_d.regs[reset_init_pkg::IDX_CORE_IRQ][2:0] = s_d.regs[reset_init_pkg::IDX_CORE_IRQ][2:0] |
                                                      core_irq_flag_set; // R3
        s_d.regs[reset_init_pkg::IDX_REQ_FLAGS] = s_d.regs[reset_init_pkg::IDX_REQ_FLAGS] | periph_irq_flag_set; // R3

        case (s_q.pwr)
            PWR_RUN: begin
                if (sleep_enter) begin
                    s_d.pwr = PWR_SLEEP;
                end
            end
            PWR_SLEEP: begin
                if (irq_wake || watchdog_timer_timeout) begin
                    s_d.pwr  = PWR_RUN;
                    s_d.wake = 1'b1;
                    // Period and mask come back full on wake, all else is kept
                    s_d.regs[reset_init_pkg::IDX_T2_PERIOD] = reset_init_pkg::WAKE_RELOAD; // R8
                    s_d.regs[reset_init_pkg::IDX_ADDR_MASK] = reset_init_pkg::WAKE_RELOAD; // R8
                    if (irq_wake && s_q.regs[reset_init_pkg::IDX_CORE_IRQ][reset_init_pkg::GLOBAL_EN_BIT]) begin
                        s_d.vec_load = 1'b1; // R4
                        s_d.vec_addr = reset_init_pkg::IRQ_VECTOR; // R4
                    end
                end
            end
            default: begin
                s_d.pwr = PWR_RUN;
            end
        endcase

        // Warm reset wins over every write and event in the same cycle; a read still returns data
        if (warm_reset) begin
            for (int i = 0; i < N; i++) begin
                s_d.regs[i] = (s_q.regs[i] & reset_init_pkg::KEEP_WARM[i]) |
                              (reset_init_pkg::POR_VAL[i] & ~reset_init_pkg::KEEP_WARM[i]); // R8 R7
            end
            if (bor_active) begin
                s_d.regs[reset_init_pkg::IDX_PWR_STAT][reset_init_pkg::PWR_SBOR_BIT] = 1'b1;
                s_d.regs[reset_init_pkg::IDX_PWR_STAT][reset_init_pkg::PWR_BOR_BIT]  = 1'b0; // R5
            end
            s_d.pwr      = PWR_RUN;
            s_d.wake     = 1'b0;
            s_d.vec_load = 1'b0;
        end
    end

    // Power-on reset is asynchronous and overrides any brown-out in flight
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= ST_POR; // R2
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_q                   = s_q.rdata;
    assign sleeping_q                = (s_q.pwr == PWR_SLEEP);
    assign wake_q                    = s_q.wake;
    assign pc_vector_load_q          = s_q.vec_load;
    assign pc_vector_addr_q          = s_q.vec_addr;
    assign global_interrupt_enable_q = s_q.regs[reset_init_pkg::IDX_CORE_IRQ][reset_init_pkg::GLOBAL_EN_BIT];
    assign sync_serial_mode_select_q = s_q.regs[reset_init_pkg::IDX_SER_CTRL][3:0];

    property p_r1_unimpl_zero;
        @(posedge clk_sys) disable iff (rst)
        (rd_en && sel.hit) |=> ((rdata_q & ~$past(reset_init_pkg::IMPL_MASK[sel.idx])) == 8'h00);
    endproperty
    a_r1_unimpl_zero: assert property (p_r1_unimpl_zero) else $error("unimplemented bit read as one"); // R1

    property p_r2_por_image;
        @(posedge clk_sys) disable iff (rst)
        $fell(rst) |-> (s_q.regs[reset_init_pkg::IDX_PWR_STAT] == 8'h10 && !global_interrupt_enable_q);
    endproperty
    a_r2_por_image: assert property (p_r2_por_image) else $error("power-on image not applied"); // R2

    property p_r3_wake_flag;
        @(posedge clk_sys) disable iff (rst)
        (sleeping_q && !warm_reset && |periph_irq_flag_set) |=>
            ((s_q.regs[reset_init_pkg::IDX_REQ_FLAGS] & $past(periph_irq_flag_set)) == $past(periph_irq_flag_set));
    endproperty
    a_r3_wake_flag: assert property (p_r3_wake_flag) else $error("wake flag not recorded"); // R3

    property p_r4_vector;
        @(posedge clk_sys) disable iff (rst)
        (sleeping_q && irq_wake && !warm_reset && global_interrupt_enable_q) |=>
            (pc_vector_load_q && wake_q && pc_vector_addr_q == 13'h0004) ##1 !pc_vector_load_q;
    endproperty
    a_r4_vector: assert property (p_r4_vector) else $error("vector not loaded on wake"); // R4

    property p_r5_bor_bit;
        @(posedge clk_sys) disable iff (rst)
        warm_reset |=> (s_q.regs[reset_init_pkg::IDX_PWR_STAT][0] ==
                        ($past(bor_active) ? 1'b0 : $past(s_q.regs[reset_init_pkg::IDX_PWR_STAT][0])));
    endproperty
    a_r5_bor_bit: assert property (p_r5_bor_bit) else $error("brown-out status bit wrong"); // R5

    property p_r6_mask_access;
        @(posedge clk_sys) disable iff (rst)
        (wr_en && addr == 9'h093 && !warm_reset && sync_serial_mode_select_q == 4'h9) |=>
            (s_q.regs[reset_init_pkg::IDX_ADDR_MASK] == $past(wdata) &&
             $stable(s_q.regs[reset_init_pkg::IDX_SLAVE_ADDR]));
    endproperty
    a_r6_mask_access: assert property (p_r6_mask_access) else $error("mask register not selected"); // R6

    property p_r7_gie_clear;
        @(posedge clk_sys) disable iff (rst)
        warm_reset |=> !global_interrupt_enable_q;
    endproperty
    a_r7_gie_clear: assert property (p_r7_gie_clear) else $error("global enable survived reset"); // R7

    property p_r8_warm_defaults;
        @(posedge clk_sys) disable iff (rst)
        warm_reset |=> (s_q.regs[reset_init_pkg::IDX_OPTION] == 8'hff &&
                        s_q.regs[reset_init_pkg::IDX_DIR_A] == 8'hff && !sleeping_q &&
                        s_q.regs[reset_init_pkg::IDX_ADC_HIGH] == $past(s_q.regs[reset_init_pkg::IDX_ADC_HIGH]));
    endproperty
    a_r8_warm_defaults: assert property (p_r8_warm_defaults) else $error("warm reset image wrong"); // R8

    property p_r8_wake_keeps;
        @(posedge clk_sys) disable iff (rst)
        (sleeping_q && !warm_reset && !wr_en && (irq_wake || watchdog_timer_timeout)) |=>
            ($stable(s_q.regs[reset_init_pkg::IDX_DIR_B]) && wake_q &&
             s_q.regs[reset_init_pkg::IDX_T2_PERIOD] == 8'hff);
    endproperty
    a_r8_wake_keeps: assert property (p_r8_wake_keeps) else $error("wake changed kept register"); // R8

    property p_r1_unmapped_zero;
        @(posedge clk_sys) disable iff (rst)
        (rd_en && !sel.hit) |=> (rdata_q == 8'h00);
    endproperty
    a_r1_unmapped_zero: assert property (p_r1_unmapped_zero) else $error("unmapped read not zero"); // R1

    property p_r1_idle_zero;
        @(posedge clk_sys) disable iff (rst)
        !rd_en |=> (rdata_q == 8'h00);
    endproperty
    a_r1_idle_zero: assert property (p_r1_idle_zero) else $error("read data without strobe"); // R1

    property p_r1_unmapped_write;
        @(posedge clk_sys) disable iff (rst)
        (wr_en && !sel.hit && !warm_reset && !adc_result_valid && core_irq_flag_set == 3'h0 &&
         periph_irq_flag_set == 8'h00 && !(sleeping_q && (irq_wake || watchdog_timer_timeout))) |=>
            $stable(s_q.regs);
    endproperty
    a_r1_unmapped_write: assert property (p_r1_unmapped_write) else $error("unmapped write stored"); // R1

    property p_r2_vector_zero;
        @(posedge clk_sys) disable iff (rst)
        $fell(rst) |-> (pc_vector_addr_q == 13'h0000 && !sleeping_q && !wake_q);
    endproperty
    a_r2_vector_zero: assert property (p_r2_vector_zero) else $error("power-on outputs wrong"); // R2

    property p_r3_core_flag;
        @(posedge clk_sys) disable iff (rst)
        (core_irq_flag_set != 3'h0 && !warm_reset) |=>
            ((s_q.regs[reset_init_pkg::IDX_CORE_IRQ][2:0] & $past(core_irq_flag_set)) == $past(core_irq_flag_set));
    endproperty
    a_r3_core_flag: assert property (p_r3_core_flag) else $error("core flag not recorded"); // R3

    property p_r4_no_vector_off;
        @(posedge clk_sys) disable iff (rst)
        (sleeping_q && irq_wake && !warm_reset && !global_interrupt_enable_q) |=> !pc_vector_load_q;
    endproperty
    a_r4_no_vector_off: assert property (p_r4_no_vector_off) else $error("vector taken with enable off"); // R4

    property p_r4_run_no_vector;
        @(posedge clk_sys) disable iff (rst)
        !sleeping_q |=> !pc_vector_load_q;
    endproperty
    a_r4_run_no_vector: assert property (p_r4_run_no_vector) else $error("vector while running"); // R4

    property p_r5_other_keeps;
        @(posedge clk_sys) disable iff (rst)
        (warm_reset && !bor_active) |=>
            (s_q.regs[reset_init_pkg::IDX_PWR_STAT][0] == $past(s_q.regs[reset_init_pkg::IDX_PWR_STAT][0]));
    endproperty
    a_r5_other_keeps: assert property (p_r5_other_keeps) else $error("status bit changed by reset"); // R5

    property p_r6_addr_plain;
        @(posedge clk_sys) disable iff (rst)
        (wr_en && addr == 9'h093 && !warm_reset && sync_serial_mode_select_q != 4'h9 &&
         !(sleeping_q && (irq_wake || watchdog_timer_timeout))) |=>
            (s_q.regs[reset_init_pkg::IDX_SLAVE_ADDR] == $past(wdata) &&
             $stable(s_q.regs[reset_init_pkg::IDX_ADDR_MASK]));
    endproperty
    a_r6_addr_plain: assert property (p_r6_addr_plain) else $error("slave address not selected"); // R6

    property p_r8_sleep_hold;
        @(posedge clk_sys) disable iff (rst)
        (sleeping_q && !warm_reset && !wr_en && !irq_wake && !watchdog_timer_timeout && !adc_result_valid &&
         core_irq_flag_set == 3'h0 && periph_irq_flag_set == 8'h00) |=> $stable(s_q.regs);
    endproperty
    a_r8_sleep_hold: assert property (p_r8_sleep_hold) else $error("register changed in sleep"); // R8

    property p_r8_wake_pulse;
        @(posedge clk_sys) disable iff (rst)
        wake_q |=> !wake_q;
    endproperty
    a_r8_wake_pulse: assert property (p_r8_wake_pulse) else $error("wake pulse too long"); // R8

    property p_r8_sleep_entry;
        @(posedge clk_sys) disable iff (rst)
        (!sleeping_q && sleep_enter && !warm_reset) |=> sleeping_q;
    endproperty
    a_r8_sleep_entry: assert property (p_r8_sleep_entry) else $error("sleep not entered"); // R8

endmodule : reset_init_register_bank

// file: test/reset_init_register_bank_tb.sv
`timescale 1ns/1ns
module reset_init_register_bank_tb;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        master_clear_reset_pin_n = 1'b1;
    logic        brownout_detect = 1'b0;
    logic        watchdog_timer_timeout = 1'b0;
    logic        sleep_enter = 1'b0;
    logic [2:0]  core_irq_flag_set = 3'h0;
    logic [7:0]  periph_irq_flag_set = 8'h00;
    logic [2:0]  osc_status = 3'h5;
    logic        adc_result_valid = 1'b0;
    logic [15:0] adc_result = 16'h0000;
    logic [8:0]  addr = 9'h000;
    logic [7:0]  wdata = 8'h00;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [7:0]  rdata_q;
    logic        sleeping_q;
    logic        wake_q;
    logic        pc_vector_load_q;
    logic [12:0] pc_vector_addr_q;
    logic        global_interrupt_enable_q;
    logic [3:0]  sync_serial_mode_select_q;
    int          failures = 0;
    int          n_compared = 0;
    int          cycles = 0;

    reset_init_register_bank DUT (
        .clk_sys(clk_sys), .rst(rst), .master_clear_reset_pin_n(master_clear_reset_pin_n),
        .brownout_detect(brownout_detect), .watchdog_timer_timeout(watchdog_timer_timeout),
        .sleep_enter(sleep_enter), .core_irq_flag_set(core_irq_flag_set),
        .periph_irq_flag_set(periph_irq_flag_set), .osc_status(osc_status),
        .adc_result_valid(adc_result_valid), .adc_result(adc_result), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .sleeping_q(sleeping_q), .wake_q(wake_q),
        .pc_vector_load_q(pc_vector_load_q), .pc_vector_addr_q(pc_vector_addr_q),
        .global_interrupt_enable_q(global_interrupt_enable_q),
        .sync_serial_mode_select_q(sync_serial_mode_select_q));

    always #2 clk_sys = ~clk_sys;

    task automatic give_verdict;
        if (failures == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Ceiling well above the roughly 150 cycles the scenarios need
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            $display("MISMATCH %0t timeout", $time);
            give_verdict();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk(16'(rdata_q), 16'(exp), "read");
    endtask : rd

    task automatic go_sleep;
        @(posedge clk_sys);
        sleep_enter <= 1'b1;
        @(posedge clk_sys);
        sleep_enter <= 1'b0;
        #1;
        chk(16'(sleeping_q), 16'h0001, "sleeping");
    endtask : go_sleep

    task automatic t_power_on_image;
        chk(16'(pc_vector_addr_q), 16'h0000, "vector after reset");
        rd(9'h081, 8'hff);
        rd(9'h089, 8'h0f);
        rd(9'h098, 8'h02);
        rd(9'h09d, 8'h01);
        rd(9'h105, 8'h08);
        rd(9'h08e, 8'h10);
        rd(9'h08f, 8'h6a);
        rd(9'h093, 8'h00);
        wr(9'h01f, 8'hff);
        rd(9'h01f, 8'hdf);
        wr(9'h089, 8'hff);
        rd(9'h089, 8'h0f);
        wr(9'h09d, 8'hff);
        rd(9'h09d, 8'h1f);
        wr(9'h0ff, 8'h5a);
        rd(9'h0ff, 8'h00);
    endtask : t_power_on_image

    task automatic t_mask_alias;
        wr(9'h093, 8'h5a);
        rd(9'h093, 8'h5a);
        wr(9'h014, 8'h09);
        #1;
        chk(16'(sync_serial_mode_select_q), 16'h0009, "mode");
        rd(9'h093, 8'hff);
        wr(9'h093, 8'h3c);
        rd(9'h093, 8'h3c);
        wr(9'h014, 8'h08);
        rd(9'h093, 8'h5a);
        wr(9'h014, 8'h00);
    endtask : t_mask_alias

    task automatic t_warm_resets;
        wr(9'h00b, 8'h80);
        wr(9'h081, 8'h55);
        wr(9'h08e, 8'h03);
        @(posedge clk_sys);
        adc_result       <= 16'ha55a;
        adc_result_valid <= 1'b1;
        @(posedge clk_sys);
        adc_result_valid <= 1'b0;
        master_clear_reset_pin_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        master_clear_reset_pin_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        chk(16'(global_interrupt_enable_q), 16'h0000, "gie after master clear");
        rd(9'h081, 8'hff);
        rd(9'h08e, 8'h03);
        rd(9'h01e, 8'ha5);
        rd(9'h09e, 8'h5a);
        wr(9'h00b, 8'h80);
        @(posedge clk_sys);
        brownout_detect <= 1'b1;
        repeat (4) @(posedge clk_sys);
        brownout_detect <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        chk(16'(global_interrupt_enable_q), 16'h0000, "gie after brown-out");
        rd(9'h08e, 8'h12);
        wr(9'h081, 8'h55);
        wr(9'h00b, 8'h80);
        @(posedge clk_sys);
        watchdog_timer_timeout <= 1'b1;
        @(posedge clk_sys);
        watchdog_timer_timeout <= 1'b0;
        #1;
        chk(16'(global_interrupt_enable_q), 16'h0000, "gie after watchdog");
        rd(9'h081, 8'hff);
        rd(9'h08e, 8'h12);
    endtask : t_warm_resets

    task automatic t_wake;
        wr(9'h08c, 8'h01);
        wr(9'h092, 8'h10);
        wr(9'h00b, 8'h80);
        go_sleep();
        @(posedge clk_sys);
        periph_irq_flag_set <= 8'h01;
        @(posedge clk_sys);
        periph_irq_flag_set <= 8'h00;
        #1;
        chk(16'({sleeping_q, wake_q, pc_vector_load_q}), 16'h0003, "irq wake");
        chk(16'(pc_vector_addr_q), 16'h0004, "vector");
        rd(9'h00c, 8'h01);
        rd(9'h092, 8'hff);
        go_sleep();
        @(posedge clk_sys);
        watchdog_timer_timeout <= 1'b1;
        @(posedge clk_sys);
        watchdog_timer_timeout <= 1'b0;
        #1;
        chk(16'({sleeping_q, wake_q, pc_vector_load_q}), 16'h0002, "watchdog wake");
        chk(16'(global_interrupt_enable_q), 16'h0001, "gie kept on wake");
        // Global enable off: the flag still wakes the core but no vector is taken
        wr(9'h00b, 8'h08);
        go_sleep();
        @(posedge clk_sys);
        core_irq_flag_set <= 3'h1;
        @(posedge clk_sys);
        core_irq_flag_set <= 3'h0;
        #1;
        chk(16'({sleeping_q, wake_q, pc_vector_load_q}), 16'h0002, "wake without vector");
        rd(9'h00b, 8'h09);
    endtask : t_wake

    task automatic t_deep_drop;
        wr(9'h08e, 8'h02);
        wr(9'h081, 8'h55);
        @(posedge clk_sys);
        rst             <= 1'b1;
        brownout_detect <= 1'b1;
        repeat (3) @(posedge clk_sys);
        brownout_detect <= 1'b0;
        @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd(9'h08e, 8'h10);
        rd(9'h081, 8'hff);
        chk(16'(pc_vector_addr_q), 16'h0000, "vector after power-on");
    endtask : t_deep_drop

    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_power_on_image();
        t_mask_alias();
        t_warm_resets();
        t_wake();
        t_deep_drop();
        give_verdict();
    end
endmodule : reset_init_register_bank_tb
